//--- spcc_pkg.sv
// Summary of operation
// - Main-loop standby floats the general-purpose output; standby is the reset default.
// - Main loop active: general-purpose output follows the level bit, low or high.
// - Mode low makes dual pins auxiliary outputs; mode high makes them polarity inputs.
// - Aux ratio: high 0 gives 10 or 12.5; high 1 gives 8 or 10.
// - Mode high: polarity input low is positive, high is negative; mode low positive.
// - Mode low selects crystal; mode high with level bit 1 selects external reference.
// - Positive polarity sinks when divided VCO leads, sources when lagging; negative swaps.
// - Main-loop standby also floats the main detector outputs.
package spcc_pkg;

  localparam int SPCC_ADDR_W = 4;
  localparam int SPCC_DATA_W = 32;

  localparam logic [SPCC_ADDR_W-1:0] SPCC_CTRL_OFS = 4'h0;
  localparam logic [SPCC_ADDR_W-1:0] SPCC_AUX_OFS = 4'h4;
  localparam logic [SPCC_ADDR_W-1:0] SPCC_STAT_OFS = 4'h8;

  localparam int SPCC_CTRL_SEC_SBY = 0;
  localparam int SPCC_CTRL_MAIN_SBY = 1;
  localparam int SPCC_CTRL_SEC_FLT = 3;
  localparam int SPCC_CTRL_MAIN_FLT = 4;
  localparam int SPCC_CTRL_LEVEL = 6;
  localparam int SPCC_CTRL_W = 7;
  localparam logic [SPCC_CTRL_W-1:0] SPCC_CTRL_RST = 7'h03;

  localparam int SPCC_AUX_LO_LSB = 0;
  localparam int SPCC_AUX_HI = 2;
  localparam int SPCC_AUX_W = 3;
  localparam logic [SPCC_AUX_W-1:0] SPCC_AUX_RST = 3'h0;

  localparam int SPCC_ST_MODE = 0;
  localparam int SPCC_ST_MPOL = 1;
  localparam int SPCC_ST_SPOL = 2;
  localparam int SPCC_ST_EXTREF = 3;
  localparam int SPCC_ST_GPOE = 4;
  localparam int SPCC_ST_GPLVL = 5;
  localparam int SPCC_ST_AUXEN = 6;

  localparam logic [1:0] SPCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPCC_RESP_SLVERR = 2'h2;

  localparam int SPCC_CNT_W = 4;
  localparam logic [SPCC_CNT_W-1:0] SPCC_PER_8 = 4'h8;
  localparam logic [SPCC_CNT_W-1:0] SPCC_PER_10 = 4'hA;
  localparam logic [SPCC_CNT_W-1:0] SPCC_PER_12 = 4'hC;
  localparam logic [SPCC_CNT_W-1:0] SPCC_PER_13 = 4'hD;

  typedef enum logic [1:0] {
    SPCC_WR_IDLE = 2'b00,
    SPCC_WR_RESP = 2'b01
  } spcc_wr_state_t;

endpackage

//--- spcc_aux_div.sv
`timescale 1ns/10ps
module spcc_aux_div
  import spcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic ratio_hi,
  input wire logic [1:0] ratio_lo,
  output logic fout
);

  // A ratio of 12.5 alternates periods of 12 and 13 reference cycles.
  logic [SPCC_CNT_W-1:0] cnt_reg;
  logic [SPCC_CNT_W-1:0] cnt_next;
  logic alt_reg;
  logic lo_zero;
  logic [SPCC_CNT_W-1:0] period;
  logic wrap;

  assign lo_zero = (ratio_lo == 2'h0);
  assign period = ratio_hi ? (lo_zero ? SPCC_PER_8 : SPCC_PER_10) :
                  (lo_zero ? SPCC_PER_10 : (alt_reg ? SPCC_PER_13 : SPCC_PER_12));
  assign wrap = (cnt_reg >= period - 4'h1);
  assign cnt_next = wrap ? 4'h0 : cnt_reg + 4'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      alt_reg <= 1'b0;
      fout <= 1'b0;
    end else if (!en) begin
      cnt_reg <= 4'h0;
      alt_reg <= 1'b0;
      fout <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (wrap) begin
        alt_reg <= ~alt_reg;
      end
      fout <= (cnt_next < {1'b0, period[SPCC_CNT_W-1:1]});
    end
  end

endmodule

//--- spcc_top.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module spcc_top
  import spcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave.
  input wire logic [SPCC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [SPCC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SPCC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [SPCC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Board pins.
  input wire logic mode_pin_i,
  input wire logic fv_main_i,
  input wire logic fr_main_i,
  output logic gp_out_o,
  output logic gp_out_oe,
  input wire logic dual_pos_i,
  output logic dual_pos_o,
  output logic dual_pos_oe,
  input wire logic dual_neg_i,
  output logic dual_neg_o,
  output logic dual_neg_oe,
  output logic ext_ref_sel_o,
  output logic sec_pol_neg_o,
  output logic main_detector_high_current_src,
  output logic main_detector_high_current_snk,
  output logic main_detector_low_current_src,
  output logic main_detector_low_current_snk
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] mode_sync_reg;
  logic [1:0] pol_main_sync_reg;
  logic [1:0] pol_sec_sync_reg;
  logic [1:0] fv_sync_reg;
  logic [1:0] fr_sync_reg;
  logic fv_last_reg;
  logic fr_last_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_sync_reg <= 2'h0;
      pol_main_sync_reg <= 2'h0;
      pol_sec_sync_reg <= 2'h0;
      fv_sync_reg <= 2'h0;
      fr_sync_reg <= 2'h0;
      fv_last_reg <= 1'b0;
      fr_last_reg <= 1'b0;
    end else begin
      mode_sync_reg <= {mode_sync_reg[0], mode_pin_i};
      pol_main_sync_reg <= {pol_main_sync_reg[0], dual_neg_i};
      pol_sec_sync_reg <= {pol_sec_sync_reg[0], dual_pos_i};
      fv_sync_reg <= {fv_sync_reg[0], fv_main_i};
      fr_sync_reg <= {fr_sync_reg[0], fr_main_i};
      fv_last_reg <= fv_sync_reg[1];
      fr_last_reg <= fr_sync_reg[1];
    end
  end

  logic mode_hi;
  assign mode_hi = mode_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Register file state.

  logic [SPCC_CTRL_W-1:0] ctrl_reg;
  logic [SPCC_AUX_W-1:0] aux_reg;
  logic main_sby;
  logic main_flt;
  logic level_bit;
  assign main_sby = ctrl_reg[SPCC_CTRL_MAIN_SBY];
  assign main_flt = ctrl_reg[SPCC_CTRL_MAIN_FLT];
  assign level_bit = ctrl_reg[SPCC_CTRL_LEVEL];

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  spcc_wr_state_t wr_state_reg;
  spcc_wr_state_t wr_state_next;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [SPCC_ADDR_W-1:0] awaddr_reg;
  logic [SPCC_DATA_W-1:0] wdata_reg;
  logic wstrb0_reg;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic aw_hold_next;
  logic w_hold_next;
  logic bvalid_next;
  logic wr_ctrl_hit;
  logic wr_aux_hit;
  logic wr_map_hit;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = (wr_state_reg == SPCC_WR_IDLE) & aw_hold_reg & w_hold_reg;
  assign aw_hold_next = (aw_hold_reg | aw_take) & ~wr_fire;
  assign w_hold_next = (w_hold_reg | w_take) & ~wr_fire;
  assign bvalid_next = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign wr_ctrl_hit = (awaddr_reg == SPCC_CTRL_OFS);
  assign wr_aux_hit = (awaddr_reg == SPCC_AUX_OFS);
  assign wr_map_hit = wr_ctrl_hit | wr_aux_hit;

  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      SPCC_WR_IDLE: begin
        if (wr_fire) begin
          wr_state_next = SPCC_WR_RESP;
        end
      end
      SPCC_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = SPCC_WR_IDLE;
        end
      end
      default: begin
        wr_state_next = SPCC_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_state_reg <= SPCC_WR_IDLE;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SPCC_RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      s_axi_awready <= ~aw_hold_next & ~bvalid_next;
      s_axi_wready <= ~w_hold_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (wr_fire) begin
        s_axi_bresp <= wr_map_hit ? SPCC_RESP_OKAY : SPCC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // Only byte lane 0 carries register bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= SPCC_CTRL_RST;
      aux_reg <= SPCC_AUX_RST;
    end else if (wr_fire && wstrb0_reg) begin
      if (wr_ctrl_hit) begin
        ctrl_reg <= wdata_reg[SPCC_CTRL_W-1:0];
      end else if (wr_aux_hit) begin
        aux_reg <= wdata_reg[SPCC_AUX_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  logic ar_take;
  logic rvalid_next;
  logic [SPCC_DATA_W-1:0] stat_word;
  logic [SPCC_DATA_W-1:0] rd_word;
  logic rd_hit;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);

  logic main_pol_neg_reg;
  logic ext_ref_reg;

  assign stat_word = {25'h0, ~mode_hi, gp_out_o, gp_out_oe, ext_ref_reg,
                      sec_pol_neg_o, main_pol_neg_reg, mode_hi};

  assign rd_hit = (s_axi_araddr == SPCC_CTRL_OFS) | (s_axi_araddr == SPCC_AUX_OFS) |
                  (s_axi_araddr == SPCC_STAT_OFS);
  assign rd_word = (s_axi_araddr == SPCC_CTRL_OFS) ? {25'h0, ctrl_reg} :
                   (s_axi_araddr == SPCC_AUX_OFS) ? {29'h0, aux_reg} :
                   (s_axi_araddr == SPCC_STAT_OFS) ? stat_word : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SPCC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? SPCC_RESP_OKAY : SPCC_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General-purpose output, reference mode and polarity.

  logic main_pol_neg;
  logic sec_pol_neg;
  assign main_pol_neg = mode_hi & pol_main_sync_reg[1];
  assign sec_pol_neg = mode_hi & pol_sec_sync_reg[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gp_out_o <= 1'b0;
      gp_out_oe <= 1'b0;
      ext_ref_reg <= 1'b0;
      ext_ref_sel_o <= 1'b0;
      main_pol_neg_reg <= 1'b0;
      sec_pol_neg_o <= 1'b0;
    end else begin
      gp_out_o <= level_bit;
      gp_out_oe <= ~main_sby;
      ext_ref_reg <= mode_hi & level_bit;
      ext_ref_sel_o <= mode_hi & level_bit;
      main_pol_neg_reg <= main_pol_neg;
      sec_pol_neg_o <= sec_pol_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Auxiliary divider and dual-purpose pins.

  logic aux_fout;
  logic aux_en;
  assign aux_en = ~mode_hi;

  spcc_aux_div u_aux_div (
    .clk(clk),
    .rst(rst),
    .en(aux_en),
    .ratio_hi(aux_reg[SPCC_AUX_HI]),
    .ratio_lo(aux_reg[SPCC_AUX_LO_LSB+1:SPCC_AUX_LO_LSB]),
    .fout(aux_fout)
  );

  // The pins turn to inputs as soon as mode is seen high, even mid-period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dual_pos_o <= 1'b0;
      dual_neg_o <= 1'b0;
      dual_pos_oe <= 1'b0;
      dual_neg_oe <= 1'b0;
    end else begin
      dual_pos_o <= aux_en & aux_fout;
      dual_neg_o <= aux_en & ~aux_fout;
      dual_pos_oe <= aux_en;
      dual_neg_oe <= aux_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main phase detector.

  logic fv_edge;
  logic fr_edge;
  logic lead_reg;
  logic lag_reg;
  logic lead_next;
  logic lag_next;
  logic pd_float;
  logic pump_snk;
  logic pump_src;

  assign fv_edge = fv_sync_reg[1] & ~fv_last_reg;
  assign fr_edge = fr_sync_reg[1] & ~fr_last_reg;
  assign lead_next = (lead_reg | fv_edge) & ~(lag_reg | fr_edge);
  assign lag_next = (lag_reg | fr_edge) & ~(lead_reg | fv_edge);
  assign pd_float = main_sby | main_flt;
  assign pump_snk = ~pd_float & (main_pol_neg ? lag_next : lead_next);
  assign pump_src = ~pd_float & (main_pol_neg ? lead_next : lag_next);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lead_reg <= 1'b0;
      lag_reg <= 1'b0;
      main_detector_high_current_src <= 1'b0;
      main_detector_high_current_snk <= 1'b0;
      main_detector_low_current_src <= 1'b0;
      main_detector_low_current_snk <= 1'b0;
    end else begin
      lead_reg <= lead_next & ~pd_float;
      lag_reg <= lag_next & ~pd_float;
      main_detector_high_current_src <= pump_src;
      main_detector_high_current_snk <= pump_snk;
      main_detector_low_current_src <= pump_src;
      main_detector_low_current_snk <= pump_snk;
    end
  end

endmodule

//--- spcc_props.sv
`timescale 1ns/10ps
module spcc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_pin_i,
  input wire logic gp_out_oe,
  input wire logic dual_pos_i,
  input wire logic dual_pos_o,
  input wire logic dual_pos_oe,
  input wire logic dual_neg_o,
  input wire logic dual_neg_oe,
  input wire logic ext_ref_sel_o,
  input wire logic sec_pol_neg_o,
  input wire logic main_detector_high_current_src,
  input wire logic main_detector_high_current_snk,
  input wire logic main_detector_low_current_src,
  input wire logic main_detector_low_current_snk
);
  wire hs = main_detector_high_current_src;
  wire hk = main_detector_high_current_snk;
  wire ls = main_detector_low_current_src;
  wire lk = main_detector_low_current_snk;
  logic [2:0] age;
  // Counts edges since reset so that delayed pin checks skip the reset history.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) age <= 3'h0;
    else if (age != 3'h4) age <= age + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_dual_input: assert property (
    mode_pin_i [*4] |-> !dual_pos_oe && !dual_neg_oe && !dual_pos_o && !dual_neg_o)
    else $error("dual pins active in input mode");
  a_dual_output: assert property (
    !mode_pin_i [*4] |-> dual_pos_oe && dual_neg_oe) else $error("dual pins not driven");
  a_aux_diff: assert property (
    dual_pos_oe && $past(dual_pos_oe) |-> dual_neg_o != dual_pos_o)
    else $error("aux pair not complementary");
  a_sec_pol: assert property (
    age == 3'h4 |-> sec_pol_neg_o == ($past(mode_pin_i, 3) && $past(dual_pos_i, 3)))
    else $error("secondary polarity wrong");
  a_ref_crystal: assert property (
    !mode_pin_i [*4] |-> !ext_ref_sel_o) else $error("external reference in mode low");
  a_pump_float: assert property (
    !gp_out_oe && $past(gp_out_oe) == 1'b0 |-> !(hs || hk || ls || lk))
    else $error("pump active in standby");
  a_pump_excl: assert property (
    !(hs && hk) && !(ls && lk)) else $error("source and sink together");
  a_pump_pair: assert property (
    hs == ls && hk == lk) else $error("pump outputs differ");
  c_aux_run: cover property (dual_pos_oe && $rose(dual_pos_o));
  c_sink: cover property ($rose(hk));
  c_source: cover property ($rose(hs));
  c_ext_ref: cover property ($rose(ext_ref_sel_o));
endmodule

bind spcc_top spcc_props u_props (.clk(clk), .rst(rst), .mode_pin_i(mode_pin_i),
  .gp_out_oe(gp_out_oe), .dual_pos_i(dual_pos_i), .dual_pos_o(dual_pos_o),
  .dual_pos_oe(dual_pos_oe), .dual_neg_o(dual_neg_o), .dual_neg_oe(dual_neg_oe),
  .ext_ref_sel_o(ext_ref_sel_o), .sec_pol_neg_o(sec_pol_neg_o),
  .main_detector_high_current_src(main_detector_high_current_src),
  .main_detector_high_current_snk(main_detector_high_current_snk),
  .main_detector_low_current_src(main_detector_low_current_src),
  .main_detector_low_current_snk(main_detector_low_current_snk));

//--- spcc_board.sv
`timescale 1ns/10ps
module spcc_board (
  input wire logic mode_req,
  input wire logic pol_main,
  input wire logic pol_sec,
  input wire logic dual_pos_o,
  input wire logic dual_pos_oe,
  input wire logic dual_neg_o,
  input wire logic dual_neg_oe,
  output logic mode_pin,
  output logic dual_pos_i,
  output logic dual_neg_i
);
  assign mode_pin = mode_req;
  // Straps act only with mode high; an undriven pin shows the inverse of its last level.
  assign dual_pos_i = dual_pos_oe ? dual_pos_o : (mode_req ? pol_sec : !dual_pos_o);
  assign dual_neg_i = dual_neg_oe ? dual_neg_o : (mode_req ? pol_main : !dual_neg_o);
endmodule

//--- spcc_top_tb.sv
`timescale 1ns/10ps
module spcc_top_tb;
  import spcc_pkg::*;
  logic clk, rst, awv, wv, bre, arv, rre, fv, fr, modr, polm, pols;
  logic [3:0] awa, ara, wst;
  logic [31:0] wd, rd, d;
  logic [1:0] br, rr, r;
  logic awr, wr, bv, arr, rv, gpo, gpoe, dpi, dpo, dpoe, dni, dno, dnoe, ext, spol, hs, hk, modp;
  logic ls, lk;
  int failures, compares, lf, c, k1, k2;
  always #10 clk = ~clk;
  spcc_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .mode_pin_i(modp),
    .fv_main_i(fv), .fr_main_i(fr), .gp_out_o(gpo), .gp_out_oe(gpoe), .dual_pos_i(dpi),
    .dual_pos_o(dpo), .dual_pos_oe(dpoe), .dual_neg_i(dni), .dual_neg_o(dno),
    .dual_neg_oe(dnoe), .ext_ref_sel_o(ext), .sec_pol_neg_o(spol),
    .main_detector_high_current_src(hs), .main_detector_high_current_snk(hk),
    .main_detector_low_current_src(ls), .main_detector_low_current_snk(lk));
  spcc_board brd (.mode_req(modr), .pol_main(polm), .pol_sec(pols), .dual_pos_o(dpo),
    .dual_pos_oe(dpoe), .dual_neg_o(dno), .dual_neg_oe(dnoe), .mode_pin(modp),
    .dual_pos_i(dpi), .dual_neg_i(dni));
  ////////////////////////////////////////
  function automatic int lfsr(input int s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] stat_exp(input int c, input logic m, pm, ps);
    return {25'h0, !m, c[6], !c[1], m && c[6], m && ps, m && pm, m};
  endfunction
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    failures++;
    conclude;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    bit done;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    done = 0;
    while (n < 50 && !done) begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) done = 1;
      if (bv) chk(br, er);
    end
    if (!done) hang;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    int n;
    bit done;
    ara <= a;
    arv <= 1'b1;
    n = 0;
    done = 0;
    while (n < 50 && !done) begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
      if (rv) begin
        d = rd;
        r = rr;
        done = 1;
      end
    end
    if (!done) hang;
  endtask
  // Counts clocks up to the next rising edge of the true aux output.
  task automatic rise(output int k);
    logic p;
    k = 0;
    p = 1'b1;
    while (k < 40 && !(dpo === 1'b1 && !p)) begin
      p = dpo;
      @(posedge clk);
      k++;
    end
    if (k == 40) hang;
  endtask
  task automatic pulse(input bit lead);
    if (lead) fv <= 1'b1;
    else fr <= 1'b1;
    repeat (2) @(posedge clk);
    fv <= 1'b0;
    fr <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    {clk, awv, wv, arv, fv, fr, modr, polm, pols} = 0;
    {rst, bre, rre} = 3'h7;
    {awa, ara, wd} = 0;
    wst = 4'hF;
    lf = 90;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(gpoe, 1'b0);
    rd_reg(SPCC_CTRL_OFS);
    chk(d, 32'h3);
    rd_reg(SPCC_AUX_OFS);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      c = (i / 2) * 64 + (i % 2) * 2 + 1;
      wr_reg(SPCC_CTRL_OFS, c, SPCC_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(gpoe, !c[1]);
      if (!c[1]) chk(gpo, c[6]);
      chk(ext, 1'b0);
      rd_reg(SPCC_STAT_OFS);
      chk(d, stat_exp(c, 1'b0, 1'b0, 1'b0));
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(SPCC_AUX_OFS, i, SPCC_RESP_OKAY);
      rise(k1);
      rise(k1);
      rise(k2);
      chk(k1 + k2, i > 3 ? (i == 4 ? 16 : 20) : (i == 0 ? 20 : 25));
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      modr <= 1'b1;
      polm <= lf[0];
      pols <= lf[1];
      c = (lf[2] ? 64 : 0) + 1;
      wr_reg(SPCC_CTRL_OFS, c, SPCC_RESP_OKAY);
      repeat (4) @(posedge clk);
      chk(ext, c[6]);
      chk(spol, pols);
      chk({dpoe, dnoe, dpo, dno}, 4'h0);
      rd_reg(SPCC_STAT_OFS);
      chk(d, stat_exp(c, 1'b1, polm, pols));
      pulse(lf[3]);
      chk({hs, hk, ls, lk}, {2{!(lf[3] ^ polm), lf[3] ^ polm}});
      pulse(!lf[3]);
      chk({hs, hk, ls, lk}, 4'h0);
    end
    // The float bit idles the detector while the main loop stays active.
    wr_reg(SPCC_CTRL_OFS, 32'h11, SPCC_RESP_OKAY);
    pulse(1'b1);
    chk({hs, hk, ls, lk, gpoe}, 5'h01);
    // A write without byte lane 0 must leave the control bits alone.
    wst <= 4'hE;
    wr_reg(SPCC_CTRL_OFS, 32'h43, SPCC_RESP_OKAY);
    wst <= 4'hF;
    rd_reg(SPCC_CTRL_OFS);
    chk(d, 32'h11);
    wr_reg(SPCC_CTRL_OFS, 32'h43, SPCC_RESP_OKAY);
    pulse(1'b1);
    chk({hs, hk, ls, lk, gpoe}, 5'h00);
    wr_reg(4'hC, 32'h5A, SPCC_RESP_SLVERR);
    wr_reg(SPCC_STAT_OFS, 32'h7F, SPCC_RESP_SLVERR);
    rd_reg(4'hC);
    chk(r, SPCC_RESP_SLVERR);
    chk(d, 32'h0);
    conclude;
  end
endmodule
